// file: core/trp_pkg.sv
// package for the table read guard and part id block
package trp_pkg;
    // register indices; the byte address is four times the index
    localparam logic [31:0] TRP_IDX_BLOCK_GUARD = 32'h0030000c;
    localparam logic [31:0] TRP_IDX_BOOT_GUARD = 32'h0030000d;
    localparam logic [31:0] TRP_IDX_ID_LOW = 32'h0003fffe;
    localparam logic [31:0] TRP_IDX_ID_HIGH = 32'h0003ffff;
    localparam int TRP_BYTE_PER_IDX = 4;
    // field positions
    localparam int TRP_BIT_BLOCK0 = 0;
    localparam int TRP_BIT_BLOCK1 = 1;
    localparam int TRP_BIT_BOOT = 6;
    localparam int TRP_REV_LSB = 0;
    localparam int TRP_PNLOW_LSB = 5;
    // unprogrammed value of every guard bit
    localparam logic TRP_GUARD_RESET = 1'b1;
    // program memory regions
    localparam logic [21:0] TRP_BOOT_LO = 22'h000000;
    localparam logic [21:0] TRP_BOOT_HI = 22'h0007ff;
    localparam logic [21:0] TRP_B0_LO = 22'h000800;
    localparam logic [21:0] TRP_B0_HI = 22'h003fff;
    localparam logic [21:0] TRP_B1_LO = 22'h004000;
    localparam logic [21:0] TRP_B1_HI = 22'h007fff;
    // arbitrary identity values
    localparam logic [2:0] TRP_PN_LOW_DEFAULT = 3'h2;
    localparam logic [4:0] TRP_REV_DEFAULT = 5'h03;
    localparam logic [7:0] TRP_PN_HIGH_DEFAULT = 8'h5c;

    typedef enum logic [1:0] {
        TRP_REGION_BOOT = 2'b00,
        TRP_REGION_B0 = 2'b01,
        TRP_REGION_B1 = 2'b10,
        TRP_REGION_OTHER = 2'b11
    } trp_region_t;

    typedef struct packed {
        logic valid;
        logic [21:0] target;
        logic [21:0] source;
    } trp_tblrd_req_t;

    typedef struct packed {
        logic done;
        logic refused;
    } trp_tblrd_rsp_t;

    typedef struct packed {
        logic boot;
        logic block1;
        logic block0;
    } trp_guard_t;
endpackage

// file: core/trp_region_check.sv
// table read region check against the guard bits
`timescale 1ns/10ps
`default_nettype none
module trp_region_check
    import trp_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // guard bits and request
    input wire trp_guard_t guard_in,
    input wire trp_tblrd_req_t req_in,
    // answer
    output trp_tblrd_rsp_t rsp_out
);
    function automatic trp_region_t region_of(input logic [21:0] addr);
        if (addr <= TRP_BOOT_HI) begin
            region_of = TRP_REGION_BOOT;
        end else if (addr >= TRP_B0_LO && addr <= TRP_B0_HI) begin
            region_of = TRP_REGION_B0;
        end else if (addr >= TRP_B1_LO && addr <= TRP_B1_HI) begin
            region_of = TRP_REGION_B1;
        end else begin
            region_of = TRP_REGION_OTHER;
        end
    endfunction

    trp_tblrd_rsp_t next_rsp;
    trp_region_t tgt;
    logic foreign;
    logic guarded;

    always_comb begin
        tgt = region_of(req_in.target);
        foreign = (region_of(req_in.source) != tgt);
        unique case (tgt)
            TRP_REGION_BOOT: guarded = ~guard_in.boot;
            TRP_REGION_B0: guarded = ~guard_in.block0;
            TRP_REGION_B1: guarded = ~guard_in.block1;
            TRP_REGION_OTHER: guarded = 1'b0;
        endcase
        next_rsp.done = req_in.valid;
        next_rsp.refused = req_in.valid & guarded & foreign;
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            rsp_out <= '0;
        end else begin
            rsp_out <= next_rsp;
        end
    end
endmodule
`default_nettype wire

// file: core/trp_top.sv
// table read guard configuration and part id registers on ahb-lite
//
// Register access over AHB-Lite was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - block-1 guard clear refuses foreign table reads of 004000h-007FFFh; set allows.
// - block-0 guard clear refuses foreign table reads of 000800h-003FFFh; set allows.
// - boot guard, bit 6, clear refuses foreign reads of 000000h-0007FFh.
// - guard bits start at one, can only be cleared, otherwise hold.
// - boot guard register bits 7 and 5..0 always read zero.
// - low id byte: bits 7..5 part number low, bits 4..0 revision.
// - high id byte holds part number bits 10..3, read only.
module trp_top
    import trp_pkg::*;
#(
    parameter logic [2:0] PN_LOW = TRP_PN_LOW_DEFAULT,
    parameter logic [4:0] REVISION = TRP_REV_DEFAULT,
    parameter logic [7:0] PN_HIGH = TRP_PN_HIGH_DEFAULT
)
(
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // ahb-lite slave
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    // table read check
    input wire trp_tblrd_req_t tblrd_in,
    output trp_tblrd_rsp_t tblrd_out,
    // eleven-bit part number for the core
    output logic [10:0] part_number_out
);
    // =====================================================
    // bus address phase capture
    trp_guard_t guard;
    trp_guard_t next_guard;
    logic wr_pend;
    logic next_wr_pend;
    logic [31:0] wr_idx;
    logic [31:0] next_wr_idx;
    logic [31:0] hrdata;
    logic [31:0] next_hrdata;
    logic [31:0] a_idx;
    logic a_take;

    // index from byte address; misaligned bits fold to an unmapped index
    always_comb begin
        a_take = hsel_in & htrans_in[1] & hready_in;
        a_idx = (haddr_in[1:0] == 2'b00) ? {2'b00, haddr_in[31:2]} : 32'hffffffff;
        next_wr_pend = a_take & hwrite_in;
        next_wr_idx = a_take ? a_idx : wr_idx;
    end

    // =====================================================
    // guard bits, clear only
    always_comb begin
        next_guard = guard;
        if (wr_pend) begin
            if (wr_idx == TRP_IDX_BLOCK_GUARD) begin
                next_guard.block0 = guard.block0 & hwdata_in[TRP_BIT_BLOCK0];
                next_guard.block1 = guard.block1 & hwdata_in[TRP_BIT_BLOCK1];
            end
            if (wr_idx == TRP_IDX_BOOT_GUARD) begin
                next_guard.boot = guard.boot & hwdata_in[TRP_BIT_BOOT];
            end
        end
        // id indices have no storage, so a write there has no effect
    end

    // =====================================================
    // read data; taken from next_guard so a read right after a write sees it
    always_comb begin
        next_hrdata = hrdata;
        if (a_take && !hwrite_in) begin
            next_hrdata = 32'h00000000;
            unique case (a_idx)
                TRP_IDX_BLOCK_GUARD: begin
                    next_hrdata[TRP_BIT_BLOCK0] = next_guard.block0;
                    next_hrdata[TRP_BIT_BLOCK1] = next_guard.block1;
                end
                TRP_IDX_BOOT_GUARD: begin
                    next_hrdata[TRP_BIT_BOOT] = next_guard.boot;
                end
                TRP_IDX_ID_LOW: begin
                    next_hrdata[TRP_PNLOW_LSB +: 3] = PN_LOW;
                    next_hrdata[TRP_REV_LSB +: 5] = REVISION;
                end
                TRP_IDX_ID_HIGH: begin
                    next_hrdata[7:0] = PN_HIGH;
                end
                default: begin
                    next_hrdata = 32'h00000000;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            guard <= '{boot: TRP_GUARD_RESET, block1: TRP_GUARD_RESET, block0: TRP_GUARD_RESET};
            wr_pend <= 1'b0;
            wr_idx <= 32'h00000000;
            hrdata <= 32'h00000000;
        end else begin
            guard <= next_guard;
            wr_pend <= next_wr_pend;
            wr_idx <= next_wr_idx;
            hrdata <= next_hrdata;
        end
    end

    // zero wait state, always okay
    assign hrdata_out = hrdata;
    assign hreadyout_out = 1'b1;
    assign hresp_out = 1'b0;
    assign part_number_out = {PN_HIGH, PN_LOW};

    // =====================================================
    // table read check
    trp_region_check u_check (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .guard_in(guard),
        .req_in(tblrd_in),
        .rsp_out(tblrd_out)
    );

    // hsize is unused: every access is treated as a whole word
    logic unused_size;
    assign unused_size = ^hsize_in;
endmodule
`default_nettype wire

// file: tb/trp_top_checker.sv
// assertion checker for the table read guard block
`timescale 1ns/10ps
`default_nettype none
module trp_top_checker
    import trp_pkg::*;
#(
    parameter logic [2:0] PN_LOW = TRP_PN_LOW_DEFAULT,
    parameter logic [4:0] REVISION = TRP_REV_DEFAULT,
    parameter logic [7:0] PN_HIGH = TRP_PN_HIGH_DEFAULT
)
(
    // clock and bus
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic hready_in,
    input wire logic [31:0] hrdata_out,
    // table read side
    input wire trp_tblrd_req_t tblrd_in,
    input wire trp_tblrd_rsp_t tblrd_out,
    input wire logic [10:0] part_number_out
);
    localparam logic [31:0] A_BOOT = 32'(TRP_IDX_BOOT_GUARD * TRP_BYTE_PER_IDX);
    localparam logic [31:0] A_LO = 32'(TRP_IDX_ID_LOW * TRP_BYTE_PER_IDX);
    localparam logic [31:0] A_HI = 32'(TRP_IDX_ID_HIGH * TRP_BYTE_PER_IDX);
    default clocking @(posedge clk_in); endclocking
    default disable iff (reset_in);
    logic rd;
    logic [21:0] t, s;
    assign rd = hsel_in && htrans_in[1] && hready_in && !hwrite_in;
    assign t = tblrd_in.target;
    assign s = tblrd_in.source;
    // ========================================
    // properties
    a_part_number: assert property (part_number_out == {PN_HIGH, PN_LOW}) else $error("part number wrong");
    a_done_follows: assert property (tblrd_in.valid |=> tblrd_out.done) else $error("no answer");
    a_no_stray: assert property (!tblrd_in.valid |=> !tblrd_out.done && !tblrd_out.refused) else $error("stray");
    a_own_block_ok: assert property (tblrd_in.valid && t inside {[TRP_B1_LO:TRP_B1_HI]}
        && s inside {[TRP_B1_LO:TRP_B1_HI]} |=> !tblrd_out.refused) else $error("own read refused");
    a_boot_self_ok: assert property (tblrd_in.valid && t <= TRP_BOOT_HI && s <= TRP_BOOT_HI
        |=> !tblrd_out.refused) else $error("boot self read refused");
    a_id_low_read: assert property (rd && haddr_in == A_LO |=> hrdata_out == {24'h0, PN_LOW, REVISION})
        else $error("id low wrong");
    a_id_high_read: assert property (rd && haddr_in == A_HI |=> hrdata_out == {24'h0, PN_HIGH})
        else $error("id high wrong");
    a_boot_pad_zero: assert property (rd && haddr_in == A_BOOT |=> hrdata_out[31:7] == 25'h0000000 && hrdata_out[5:0] == 6'h00)
        else $error("unused bits set");
    c_refused: cover property (tblrd_out.refused);
    c_id_read: cover property (rd && haddr_in == A_LO);
    c_allowed: cover property (tblrd_out.done && !tblrd_out.refused);
endmodule
bind trp_top trp_top_checker #(.PN_LOW(PN_LOW), .REVISION(REVISION), .PN_HIGH(PN_HIGH)) trp_top_checker_inst (
    .clk_in(clk_in), .reset_in(reset_in), .hsel_in(hsel_in), .haddr_in(haddr_in), .htrans_in(htrans_in),
    .hwrite_in(hwrite_in), .hready_in(hready_in), .hrdata_out(hrdata_out), .tblrd_in(tblrd_in),
    .tblrd_out(tblrd_out), .part_number_out(part_number_out));
`default_nettype wire

// file: tb/tb.sv
// self-checking testbench for the table read guard block
`timescale 1ns/10ps
`default_nettype none
module tb
    import trp_pkg::*;
;
    localparam logic [31:0] A_BLK = 32'(TRP_IDX_BLOCK_GUARD * TRP_BYTE_PER_IDX);
    localparam logic [31:0] A_BOOT = 32'(TRP_IDX_BOOT_GUARD * TRP_BYTE_PER_IDX);
    localparam logic [31:0] A_LO = 32'(TRP_IDX_ID_LOW * TRP_BYTE_PER_IDX);
    localparam logic [31:0] A_HI = 32'(TRP_IDX_ID_HIGH * TRP_BYTE_PER_IDX);
    logic clk_in = 1'b0, reset_in = 1'b1, hsel = 1'b0, hwrite = 1'b0, hready, hresp;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rdata;
    logic [10:0] pnum;
    trp_tblrd_req_t req = '0;
    trp_tblrd_rsp_t rsp;
    int bad_count = 0, n_tests = 0;
    // hready loops back from the only slave
    trp_top trp_top_inst (.clk_in(clk_in), .reset_in(reset_in), .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready),
        .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp), .tblrd_in(req), .tblrd_out(rsp),
        .part_number_out(pnum));
    initial forever #2 clk_in = ~clk_in;
    // ========================================
    // shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk_in);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        @(posedge clk_in);
        while (hready !== 1'b1) @(posedge clk_in);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk_in);
        while (hready !== 1'b1) @(posedge clk_in);
        rdata = hrdata;
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rdata, exp);
        // slave must answer at once and always with an okay response
        chk({30'h0, hready, hresp}, 32'h00000002);
    endtask
    task automatic tr(input logic [21:0] t, input logic [21:0] s, input logic refused);
        @(posedge clk_in);
        req <= '{valid: 1'b1, target: t, source: s};
        @(posedge clk_in);
        req <= '0;
        #1;
        chk({30'h0, rsp}, {30'h0, 1'b1, refused});
    endtask
    task automatic do_reset;
        @(posedge clk_in);
        reset_in <= 1'b1;
        repeat (12) @(posedge clk_in);
        reset_in <= 1'b0;
    endtask
    task automatic report_and_stop;
        $display("mismatches %0d checks %0d", bad_count, n_tests);
        if (bad_count == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // ========================================
    // scenarios
    task automatic t_fresh;
        rd(A_BLK, 32'h3);
        rd(A_BOOT, 32'h40);
        rd(A_LO, {24'h0, TRP_PN_LOW_DEFAULT, TRP_REV_DEFAULT});
        rd(A_HI, {24'h0, TRP_PN_HIGH_DEFAULT});
        chk({21'h0, pnum}, {21'h0, TRP_PN_HIGH_DEFAULT, TRP_PN_LOW_DEFAULT});
        rd(32'h100, 32'h0);
        tr(22'h004000, 22'h000000, 1'b0);
        tr(22'h000800, 22'h004000, 1'b0);
        tr(22'h000000, 22'h000800, 1'b0);
    endtask
    task automatic t_id_write;
        bus(1'b1, A_LO, 32'hffffffff);
        bus(1'b1, A_HI, 32'h0);
        bus(1'b1, A_BOOT, 32'hff);
        rd(A_LO, {24'h0, TRP_PN_LOW_DEFAULT, TRP_REV_DEFAULT});
        rd(A_HI, {24'h0, TRP_PN_HIGH_DEFAULT});
        rd(A_BOOT, 32'h40);
    endtask
    task automatic t_guards;
        bus(1'b1, A_BLK, 32'h1);
        rd(A_BLK, 32'h1);
        tr(22'h007fff, 22'h003fff, 1'b1);
        tr(22'h007fff, 22'h004000, 1'b0);
        tr(22'h003fff, 22'h000000, 1'b0);
        bus(1'b1, A_BLK, 32'h3);
        rd(A_BLK, 32'h1);
        bus(1'b1, A_BLK, 32'h0);
        tr(22'h000800, 22'h0007ff, 1'b1);
        tr(22'h003fff, 22'h000800, 1'b0);
        bus(1'b1, A_BOOT, 32'h0);
        rd(A_BOOT, 32'h0);
        tr(22'h0007ff, 22'h000800, 1'b1);
        tr(22'h000000, 22'h0007ff, 1'b0);
        tr(22'h008000, 22'h000000, 1'b0);
    endtask
    task automatic t_rereset;
        do_reset();
        rd(A_BLK, 32'h3);
        rd(A_BOOT, 32'h40);
        tr(22'h0007ff, 22'h004000, 1'b0);
    endtask
    initial begin
        do_reset();
        t_fresh();
        t_id_write();
        t_guards();
        t_rereset();
        report_and_stop();
    end
    // run needs well under 1000 cycles
    initial begin
        repeat (4000) @(posedge clk_in);
        bad_count++;
        report_and_stop();
    end
endmodule
`default_nettype wire
